// ### hdl/i2rp_pkg.sv
package i2rp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte and address layout
  localparam int         BYTE_W      = 8;
  localparam int         DEV_ADDR_W  = 7;
  // Seven-bit target addresses: write/read bytes 0x58/0x59 and 0x5A/0x5B
  localparam logic [6:0] DEV_ADDR0   = 7'h2C;
  localparam logic [6:0] DEV_ADDR1   = 7'h2D;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic       STRAP_PULLUP = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Counters
  localparam logic [3:0] BIT_ZERO     = 4'h0;
  localparam logic [3:0] BIT_ONE      = 4'h1;
  localparam logic [3:0] BIT_LAST     = 4'h8;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [7:0] PTR_STEP     = 8'h01;
  localparam int         STRAP_CNT_W  = 4;
  localparam int         STRAP_MAX    = 15;
  localparam logic [3:0] STRAP_ONE    = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ADDR    = 3'h1,
    ST_ADDR_AK = 3'h2,
    ST_RX      = 3'h3,
    ST_RX_AK   = 3'h4,
    ST_TX      = 3'h5,
    ST_TX_AK   = 3'h6
  } i2rp_link_state_type;

  typedef struct packed {
    logic              wr;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } i2rp_req_type;

  typedef struct packed {
    i2rp_link_state_type    state;
    logic [3:0]             bit_cnt;
    logic [BYTE_W-1:0]      shreg;
    logic                   is_read;
    logic                   have_sub;
    logic                   acked;
    logic [BYTE_W-1:0]      ptr;
    logic                   sda_oe;
    logic                   sda_out;
    logic                   scl_q;
    logic                   sda_q;
    logic [STRAP_CNT_W-1:0] strap_cnt;
    logic                   strap_done;
    logic [DEV_ADDR_W-1:0]  dev_addr;
    i2rp_req_type           req;
    logic                   req_tgl;
    logic                   ack_q;
    logic [BYTE_W-1:0]      rdata;
  } i2rp_link_type;

  typedef struct packed {
    logic              seen;
    logic              reg_wr;
    logic              reg_rd;
    logic [BYTE_W-1:0] reg_addr;
    logic [BYTE_W-1:0] reg_wdata;
    logic [BYTE_W-1:0] rdata_hold;
    logic              ack_tgl;
  } i2rp_sys_type;

endpackage : i2rp_pkg

// ### hdl/i2rp_sync.sv
`timescale 1ns/1ps
module i2rp_sync #(
  parameter int   WIDTH     = 1,
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset of the receiving domain
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } i2rp_sync_state_type;

  i2rp_sync_state_type st;
  i2rp_sync_state_type next_st;

  if (WIDTH < 1) begin : g_bad_width
    $error("i2rp_sync: WIDTH must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= {(2 * WIDTH){RESET_VAL}};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule : i2rp_sync

// ### hdl/i2rp_top.sv
`timescale 1ns/1ps
// How it works
// - Target only; never drives SCL, never stretches, never arbitrates.
// - Address taken from fault-output strap after reset: 0x58/0x59 or 0x5A/0x5B.
// - Link oversampled fast enough for 100 and 400 kbit/s host clocking.
// - All link bytes are eight bits, most significant bit first.
// - Accepted byte acknowledged by holding SDA low for the whole ninth clock.
// - SDA fall with SCL high is start; SDA rise with SCL high is stop.
// - Seven address bits plus direction; respond only on match with own address.
// - Any number of bytes per transfer; pointer simply wraps.
// - Write: address, subaddress, data each acknowledged, then stop.
// - Each further written byte acknowledged, stored, pointer advanced by one.
// - Read: subaddress write, repeated start, read address, then byte driven.
// - After each host-acknowledged byte, pointer advances and next byte goes out.
// - Host not-acknowledge ends the read; SDA released, no more data driven.
// - Each fetch pulses a read strobe so memory registers clear on read.
// - Reset aborts any transfer and returns all state to defaults.
module i2rp_top
  import i2rp_pkg::*;
#(
  parameter int STRAP_SETTLE = 3
) (
  // System clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  // Two-wire link
  input  wire logic              CLK_LINK,
  input  wire logic              SCL,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE,
  // Address strap sensed on the fault output
  input  wire logic              ADDR_STRAP,
  // Register bank
  output logic                   REG_WR,
  output logic                   REG_RD,
  output logic      [BYTE_W-1:0] REG_ADDR,
  output logic      [BYTE_W-1:0] REG_WDATA,
  input  wire logic [BYTE_W-1:0] REG_RDATA
);

  localparam logic [STRAP_CNT_W-1:0] STRAP_LAST =
    STRAP_CNT_W'(STRAP_SETTLE);

  if (STRAP_SETTLE < 2 || STRAP_SETTLE > STRAP_MAX) begin : g_bad_settle
    $error("i2rp_top: STRAP_SETTLE must lie in 2 to 15");
  end

  i2rp_link_type link;
  i2rp_link_type next_link;
  i2rp_sys_type  sys;
  i2rp_sys_type  next_sys;

  logic       link_rst;
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       strap_s;
  logic       ack_s;
  logic       req_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       byte_done;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings

  // Reset reaches the link domain at once, leaves it synchronously
  i2rp_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_rst_link (
    .clk (CLK_LINK),
    .rst (RST),
    .d   (1'b0),
    .q   (link_rst)
  );

  // Pins share one synchroniser so SCL and SDA keep their relative order
  i2rp_sync #(
    .WIDTH     (3),
    .RESET_VAL (1'b1)
  ) u_pins (
    .clk (CLK_LINK),
    .rst (link_rst),
    .d   ({ADDR_STRAP, SDA_IN, SCL}),
    .q   (pins_s)
  );

  i2rp_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_ack (
    .clk (CLK_LINK),
    .rst (link_rst),
    .d   (sys.ack_tgl),
    .q   (ack_s)
  );

  i2rp_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_req (
    .clk (CLK_SYS),
    .rst (RST),
    .d   (link.req_tgl),
    .q   (req_s)
  );

  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign strap_s = pins_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus events
  // Start and stop need SCL high on two samples in a row, so an SDA change
  // landing in the same sample as an SCL fall is not mistaken for either.
  assign scl_rise  = scl_s & ~link.scl_q;
  assign scl_fall  = ~scl_s & link.scl_q;
  assign bus_start = scl_s & link.scl_q & link.sda_q & ~sda_s;
  assign bus_stop  = scl_s & link.scl_q & ~link.sda_q & sda_s;
  assign byte_done = scl_fall & (link.bit_cnt == BIT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain
  // Limitation: a fetch has about half an SCL period to return; there is
  // no clock stretching to fall back on if the bank answers late.
  always_comb begin
    next_link       = link;
    next_link.scl_q = scl_s;
    next_link.sda_q = sda_s;

    if (!link.strap_done) begin
      if (link.strap_cnt == STRAP_LAST) begin
        next_link.strap_done = 1'b1;
        next_link.dev_addr   = (strap_s == STRAP_PULLUP) ?
                               DEV_ADDR1 : DEV_ADDR0;
      end else begin
        next_link.strap_cnt = link.strap_cnt + STRAP_ONE;
      end
    end

    if (ack_s != link.ack_q) begin
      next_link.ack_q = ack_s;
      next_link.rdata = sys.rdata_hold;
    end

    if (bus_start) begin
      next_link.state    = ST_ADDR;
      next_link.bit_cnt  = BIT_ZERO;
      next_link.have_sub = 1'b0;
      next_link.sda_oe   = 1'b0;
    end else if (bus_stop) begin
      next_link.state  = ST_IDLE;
      next_link.sda_oe = 1'b0;
    end else begin
      case (link.state)
        ST_IDLE: begin
          next_link.sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_link.shreg   = {link.shreg[BYTE_W-2:0], sda_s};
            next_link.bit_cnt = link.bit_cnt + BIT_ONE;
          end else if (byte_done) begin
            next_link.bit_cnt = BIT_ZERO;
            if (link.strap_done &&
                link.shreg[BYTE_W-1:1] == link.dev_addr) begin
              next_link.state   = ST_ADDR_AK;
              next_link.sda_oe  = 1'b1;
              next_link.is_read = (link.shreg[0] == DIR_READ);
              if (link.shreg[0] == DIR_READ) begin
                next_link.req.wr   = 1'b0;
                next_link.req.addr = link.ptr;
                next_link.req_tgl  = ~link.req_tgl;
                next_link.ptr      = link.ptr + PTR_STEP;
              end
            end else begin
              next_link.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_AK: begin
          if (scl_fall) begin
            if (link.is_read) begin
              next_link.state   = ST_TX;
              next_link.shreg   = link.rdata;
              next_link.sda_oe  = ~link.rdata[BYTE_W-1];
              next_link.bit_cnt = BIT_ONE;
            end else begin
              next_link.state  = ST_RX;
              next_link.sda_oe = 1'b0;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_link.shreg   = {link.shreg[BYTE_W-2:0], sda_s};
            next_link.bit_cnt = link.bit_cnt + BIT_ONE;
          end else if (byte_done) begin
            next_link.state  = ST_RX_AK;
            next_link.sda_oe = 1'b1;
            if (!link.have_sub) begin
              next_link.ptr      = link.shreg;
              next_link.have_sub = 1'b1;
            end else begin
              next_link.req.wr   = 1'b1;
              next_link.req.addr = link.ptr;
              next_link.req.data = link.shreg;
              next_link.req_tgl  = ~link.req_tgl;
              next_link.ptr      = link.ptr + PTR_STEP;
            end
          end
        end
        ST_RX_AK: begin
          if (scl_fall) begin
            next_link.state   = ST_RX;
            next_link.sda_oe  = 1'b0;
            next_link.bit_cnt = BIT_ZERO;
          end
        end
        ST_TX: begin
          // Open drain: a one is sent by letting go of the line
          if (scl_fall) begin
            if (link.bit_cnt == BIT_LAST) begin
              next_link.state  = ST_TX_AK;
              next_link.sda_oe = 1'b0;
              next_link.acked  = 1'b0;
            end else begin
              next_link.shreg   = {link.shreg[BYTE_W-2:0], 1'b0};
              next_link.sda_oe  = ~link.shreg[BYTE_W-2];
              next_link.bit_cnt = link.bit_cnt + BIT_ONE;
            end
          end
        end
        ST_TX_AK: begin
          if (scl_rise) begin
            if (!sda_s) begin
              next_link.acked    = 1'b1;
              next_link.req.wr   = 1'b0;
              next_link.req.addr = link.ptr;
              next_link.req_tgl  = ~link.req_tgl;
              next_link.ptr      = link.ptr + PTR_STEP;
            end else begin
              next_link.state  = ST_IDLE;
              next_link.sda_oe = 1'b0;
            end
          end else if (scl_fall && link.acked) begin
            next_link.state   = ST_TX;
            next_link.shreg   = link.rdata;
            next_link.sda_oe  = ~link.rdata[BYTE_W-1];
            next_link.bit_cnt = BIT_ONE;
          end
        end
        default: begin
          next_link.state  = ST_IDLE;
          next_link.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_LINK or posedge link_rst) begin
    if (link_rst) begin
      // Edge history starts at the idle bus level, so no false edge follows
      link       <= '0;
      link.scl_q <= 1'b1;
      link.sda_q <= 1'b1;
    end else begin
      link <= next_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain
  // Request fields are held by the link side from the toggle until the
  // next byte, far longer than the synchroniser delay, so they are stable.
  always_comb begin
    next_sys        = sys;
    next_sys.seen   = req_s;
    next_sys.reg_wr = 1'b0;
    next_sys.reg_rd = 1'b0;
    if (sys.reg_wr || sys.reg_rd) begin
      next_sys.ack_tgl = ~sys.ack_tgl;
      if (sys.reg_rd) begin
        next_sys.rdata_hold = REG_RDATA;
      end
    end
    if (req_s != sys.seen) begin
      next_sys.reg_wr    = link.req.wr;
      next_sys.reg_rd    = ~link.req.wr;
      next_sys.reg_addr  = link.req.addr;
      next_sys.reg_wdata = link.req.data;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; SCL is never driven
  assign SDA_OUT   = link.sda_out;
  assign SDA_OE    = link.sda_oe;
  assign REG_WR    = sys.reg_wr;
  assign REG_RD    = sys.reg_rd;
  assign REG_ADDR  = sys.reg_addr;
  assign REG_WDATA = sys.reg_wdata;

endmodule : i2rp_top

// ### sim/i2rp_assertions.sv
`timescale 1ns/1ps
module i2rp_assertions
  import i2rp_pkg::*;
(
  // Clocks and reset
  input wire logic              CLK_SYS,
  input wire logic              CLK_LINK,
  input wire logic              RST,
  // Link
  input wire logic              SCL,
  input wire logic              SDA_OUT,
  input wire logic              SDA_OE,
  // Register bank
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [BYTE_W-1:0] REG_ADDR,
  input wire logic [BYTE_W-1:0] REG_WDATA
);
  ////////////////////////////////////////
  // Bank side
  property p_rst_clear;
    @(posedge CLK_SYS) disable iff (RST)
    $fell(RST) |-> !REG_WR && !REG_RD && REG_ADDR == 8'h00
      && REG_WDATA == 8'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("bank outputs not cleared by reset");
  // One access per link byte, so a pulse is followed by a long gap
  property p_wr_gap;
    @(posedge CLK_SYS) disable iff (RST)
    REG_WR |=> !(REG_WR || REG_RD) [*8];
  endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("write strobe not a lone pulse");
  property p_rd_gap;
    @(posedge CLK_SYS) disable iff (RST)
    REG_RD |=> !(REG_RD || REG_WR) [*8];
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read strobe not a lone pulse");
  property p_addr_hold;
    @(posedge CLK_SYS) disable iff (RST)
    $changed(REG_ADDR) || $changed(REG_WDATA) |-> REG_WR || REG_RD;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("bank address moved without an access");
  ////////////////////////////////////////
  // Link side
  property p_out_low;
    @(posedge CLK_LINK) disable iff (RST)
    SDA_OE |-> SDA_OUT == 1'b0;
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("data pin driven high");
  property p_oe_scl_low;
    @(posedge CLK_LINK) disable iff (RST)
    $changed(SDA_OE) |-> !SCL;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data enable moved while clock high");
  property p_ack_hold;
    @(posedge CLK_LINK) disable iff (RST)
    $rose(SCL) && SDA_OE |=> SDA_OE [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data low not held through clock high");
endmodule : i2rp_assertions

// ### sim/i2rp_host.sv
`timescale 1ns/1ps
module i2rp_host #(
  parameter int Q = 32
) (
  // Timing reference
  input  wire logic clk,
  input  wire logic sda,
  // Bus drive
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bit in system clocks: 32 gives about 390 kbit/s, 125 gives 100
  int quarter = Q;
  task automatic wait_q;
    repeat (quarter) @(negedge clk);
  endtask : wait_q
  // Also a repeated start: data released while clock is low
  task automatic start;
    sda_low = 1'b0;
    wait_q();
    scl = 1'b1;
    wait_q();
    sda_low = 1'b1;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    wait_q();
    scl = 1'b1;
    wait_q();
    sda_low = 1'b0;
    wait_q();
  endtask : stop
  task automatic xfer_bit(input logic b, output logic r);
    sda_low = !b;
    wait_q();
    scl = 1'b1;
    wait_q();
    r = sda;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask : xfer_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(b[i], r);
    xfer_bit(1'b1, r);
    ack = !r;
  endtask : send_byte
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      b[i] = r;
    end
    xfer_bit(!ack, r);
  endtask : recv_byte
endmodule : i2rp_host

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import i2rp_pkg::*;
  logic       clk_sys, clk_link, rst, strap, scl, host_low, sda;
  logic       sda_out, sda_oe, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] bank [256];
  logic [7:0] pat [3] = '{8'h11, 8'h22, 8'h33};
  int         failures = 0, checked = 0, wr_cnt = 0, rd_cnt = 0, cycles = 0;
  // Open-drain line with pull-up
  assign sda = !(host_low || (sda_oe && !sda_out));
  assign reg_rdata = bank[reg_addr];
  i2rp_top dut (
    .CLK_SYS(clk_sys), .RST(rst), .CLK_LINK(clk_link), .SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_STRAP(strap),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata)
  );
  i2rp_host host (.clk(clk_sys), .sda(sda), .scl(scl), .sda_low(host_low));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = !clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #40 clk_link = !clk_link;
  end
  ////////////////////////////////////////
  // Register bank and run limit
  always @(posedge clk_sys) begin
    if (reg_wr) begin
      bank[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (reg_rd)
      rd_cnt <= rd_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // Reset is asynchronous in both domains; the link side leaves it two
  // link edges later, and the strap is taken a few edges after that
  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    repeat (24) @(negedge clk_link);
  endtask : do_reset
  ////////////////////////////////////////
  // Scenarios
  task automatic t_nomatch;
    logic ack;
    host.start();
    host.send_byte(8'h5A, ack);
    host.stop();
    check_val({7'h00, ack}, 8'h00);
  endtask : t_nomatch
  task automatic t_seq_write;
    logic ack;
    host.start();
    host.send_byte(8'h58, ack);
    check_val({7'h00, ack}, 8'h01);
    host.send_byte(8'hFE, ack);
    check_val({7'h00, ack}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      host.send_byte(pat[i], ack);
      check_val({7'h00, ack}, 8'h01);
    end
    host.stop();
    check_val(bank[8'hFE], pat[0]);
    check_val(bank[8'hFF], pat[1]);
    check_val(bank[8'h00], pat[2]);
  endtask : t_seq_write
  task automatic t_seq_read;
    logic       ack;
    logic [7:0] b;
    int         n0;
    host.start();
    host.send_byte(8'h58, ack);
    host.send_byte(8'hFE, ack);
    n0 = rd_cnt;
    host.start();
    host.send_byte(8'h59, ack);
    check_val({7'h00, ack}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      host.recv_byte(i < 2, b);
      check_val(b, pat[i]);
    end
    check_val({7'h00, sda_oe}, 8'h00);
    host.stop();
    check_val(8'(rd_cnt - n0), 8'h03);
  endtask : t_seq_read
  task automatic t_abort;
    logic ack;
    logic r;
    int   n0;
    n0 = wr_cnt;
    host.start();
    repeat (3) host.xfer_bit(1'b0, r);
    host.start();
    host.send_byte(8'h58, ack);
    check_val({7'h00, ack}, 8'h01);
    host.send_byte(8'h40, ack);
    repeat (4) host.xfer_bit(1'b1, r);
    host.stop();
    check_val(8'(wr_cnt - n0), 8'h00);
  endtask : t_abort
  task automatic t_slow_write;
    logic ack;
    host.quarter = 125;
    host.start();
    host.send_byte(8'h58, ack);
    check_val({7'h00, ack}, 8'h01);
    host.send_byte(8'h30, ack);
    host.send_byte(8'h5C, ack);
    check_val({7'h00, ack}, 8'h01);
    host.stop();
    host.quarter = 32;
    check_val(bank[8'h30], 8'h5C);
  endtask : t_slow_write
  task automatic t_reset_abort;
    logic       ack;
    logic       r;
    logic [7:0] b;
    host.start();
    host.send_byte(8'h58, ack);
    repeat (5) host.xfer_bit(1'b1, r);
    do_reset(1'b1);
    check_val({7'h00, sda_oe}, 8'h00);
    host.stop();
    host.start();
    host.send_byte(8'h58, ack);
    check_val({7'h00, ack}, 8'h00);
    host.stop();
    // Read at the current pointer, which reset must have returned to zero
    host.start();
    host.send_byte(8'h5B, ack);
    check_val({7'h00, ack}, 8'h01);
    host.recv_byte(1'b0, b);
    host.stop();
    check_val(b, pat[2]);
    host.start();
    host.send_byte(8'h5A, ack);
    check_val({7'h00, ack}, 8'h01);
    host.send_byte(8'h20, ack);
    host.send_byte(8'h77, ack);
    host.stop();
    check_val(bank[8'h20], 8'h77);
  endtask : t_reset_abort
  initial begin
    strap = 1'b0;
    rst = 1'b1;
    do_reset(1'b0);
    t_nomatch();
    t_seq_write();
    t_seq_read();
    t_abort();
    t_slow_write();
    t_reset_abort();
    stop_test();
  end
endmodule : testbench

bind i2rp_top i2rp_assertions chk (
  .CLK_SYS(CLK_SYS), .CLK_LINK(CLK_LINK), .RST(RST), .SCL(SCL),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA)
);
